// >>> hw/evi_pkg.sv
// Purpose: Shared constants of the encoder velocity and event block
// Assumes: 32-bit AXI4-Lite register port, byte addresses
// Notes: Only the low four event bits exist; the rest read as zero
package evi_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   // Register byte offsets
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_PERIOD_LOAD = 8'h10;
   localparam logic [7:0] OFS_TIMER_VALUE = 8'h14;
   localparam logic [7:0] OFS_PULSE_TALLY = 8'h18;
   localparam logic [7:0] OFS_MEAS_VELOCITY = 8'h1C;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h20;
   localparam logic [7:0] OFS_RAW_STATUS = 8'h24;
   localparam logic [7:0] OFS_MASKED_CLEAR = 8'h28;
   // Control fields
   localparam int unsigned CTL_VEL_EN_BIT = 5;
   localparam int unsigned CTL_DIV_LSB = 6;
   localparam int unsigned CTL_DIV_MSB = 8;
   localparam logic [31:0] CTL_WR_MASK = 32'h000001E0;
   // Event bit positions
   localparam int unsigned EV_INDEX = 0;
   localparam int unsigned EV_TIMER = 1;
   localparam int unsigned EV_DIR = 2;
   localparam int unsigned EV_ERROR = 3;
   localparam int unsigned EV_W = 4;
   // Reset values
   localparam logic [31:0] CONTROL_RST = 32'h00000000;
   localparam logic [31:0] LOAD_RST = 32'h00000000;
   localparam logic [31:0] TIMER_RST = 32'h00000000;
   localparam logic [31:0] TALLY_RST = 32'h00000000;
   localparam logic [31:0] SPEED_RST = 32'h00000000;
   localparam logic [3:0] EVENT_RST = 4'h0;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : evi_pkg

// >>> hw/evi_top.sv
// Purpose: Encoder velocity measurement and event latching
// Assumes: Phase and index pins are asynchronous; one clock
// Notes: All state freezes while ce_i is low
// Functional notes
// R1 - Running tally readable, read-only, 32 bits
// R2 - Tally frozen while velocity enable clear
// R3 - Speed register holds previous period count
// R4 - Speed register frozen while velocity disabled
// R5 - Software uses speed; tally informational only
// R6 - Tally is full width, resets zero
// R7 - Interrupt when latched event and enabled
// R8 - Bit 3 is phase error
// R9 - Bit 2 is direction change
// R10 - Bit 1 is timer expiry
// R11 - Bit 0 is index pulse
// R12 - Raw status shows all latched events
// R13 - Status bit one once event latched
// R14 - Masked status shows only enabled events
// R15 - Writing one to masked status clears
// R16 - Upper bits reserved, read zero here
// R17 - Velocity enable gates timer, tally, speed
// R18 - Predivider divides pulses by 1 to 128
// R19 - Timer reloads after zero, period load+1
// R20 - Period end captures, restarts, latches expiry
// R21 - Zero writes keep events; raw writes ignored
`timescale 1ns/1ps
`default_nettype none
module evi_top (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic phase_a_i,
   input wire logic phase_b_i,
   input wire logic index_i,
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   output logic irq_o
);
   logic aw_ready_reg;
   logic w_ready_reg;
   logic aw_held_reg;
   logic w_held_reg;
   logic [7:0] wr_addr_reg;
   logic [31:0] wr_data_reg;
   logic [3:0] wr_strb_reg;
   logic b_valid_reg;
   logic [1:0] b_resp_reg;
   logic ar_ready_reg;
   logic r_valid_reg;
   logic [31:0] r_data_reg;
   logic [1:0] r_resp_reg;
   logic [31:0] control_reg;
   logic [31:0] load_reg;
   logic [31:0] timer_reg;
   logic [31:0] tally_reg;
   logic [31:0] speed_reg;
   logic [3:0] enable_reg;
   logic [3:0] raw_reg;
   logic irq_reg;
   logic [2:0] sync1_reg;
   logic [2:0] sync2_reg;
   logic [2:0] pins_q_reg;
   logic dir_reg;
   logic [6:0] div_cnt_reg;
   logic do_write;
   logic [31:0] strb_mask;
   logic vel_en;
   logic [2:0] div_sel;
   logic [6:0] div_mask;
   logic a_chg;
   logic b_chg;
   logic step;
   logic dir_now;
   logic inc;
   logic expire;
   logic [3:0] ev_set;
   logic [3:0] ev_clr;
   logic wr_hit_ok;

   assign do_write = aw_held_reg && w_held_reg && !b_valid_reg;
   assign vel_en = control_reg[evi_pkg::CTL_VEL_EN_BIT];
   assign div_sel = control_reg[evi_pkg::CTL_DIV_MSB:evi_pkg::CTL_DIV_LSB];
   assign div_mask = 7'((8'h01 << div_sel) - 8'h01);
   assign a_chg = sync2_reg[0] ^ pins_q_reg[0];
   assign b_chg = sync2_reg[1] ^ pins_q_reg[1];
   assign step = a_chg ^ b_chg;
   // Forward reads as zero like the reset direction, so no false change event after reset
   assign dir_now = !(pins_q_reg[0] ^ sync2_reg[1]);
   // Each valid step counts; the predivider passes one of 2**n
   assign inc = vel_en && step && ((div_cnt_reg & div_mask) == div_mask); // see R18
   assign expire = vel_en && (timer_reg == 32'h00000000); // see R17

   generate
      for (genvar i = 0; i < 4; i++) begin : g_strb
         assign strb_mask[8*i+7:8*i] = {8{wr_strb_reg[i]}};
      end
   endgenerate

   always_comb begin
      ev_set = 4'h0;
      ev_set[evi_pkg::EV_ERROR] = a_chg && b_chg; // see R8
      ev_set[evi_pkg::EV_DIR] = step && (dir_now != dir_reg); // see R9
      ev_set[evi_pkg::EV_TIMER] = expire; // see R10
      ev_set[evi_pkg::EV_INDEX] = sync2_reg[2] && !pins_q_reg[2]; // see R11
   end

   // Only the masked-clear offset clears; raw status ignores writes
   assign ev_clr = (do_write && wr_addr_reg == evi_pkg::OFS_MASKED_CLEAR)
      ? (wr_data_reg[3:0] & {4{wr_strb_reg[0]}}) : 4'h0; // see R15, R21

   always_comb begin
      case (wr_addr_reg)
         evi_pkg::OFS_CONTROL,
         evi_pkg::OFS_PERIOD_LOAD,
         evi_pkg::OFS_IRQ_ENABLE,
         evi_pkg::OFS_MASKED_CLEAR: wr_hit_ok = 1'b1;
         default: wr_hit_ok = 1'b0;
      endcase
   end

   // Pin synchronisers; first stage feeds only the second
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         sync1_reg <= 3'h0;
         sync2_reg <= 3'h0;
         pins_q_reg <= 3'h0;
      end else if (ce_i) begin
         sync1_reg <= {index_i, phase_b_i, phase_a_i};
         sync2_reg <= sync1_reg;
         pins_q_reg <= sync2_reg;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         dir_reg <= 1'b0;
      end else if (ce_i && step) begin
         dir_reg <= dir_now;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         div_cnt_reg <= 7'h00;
      end else if (ce_i && vel_en && step) begin
         div_cnt_reg <= div_cnt_reg + 7'h01; // see R18
      end
   end

   // Velocity timer counts down, reloading the cycle after zero
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         timer_reg <= evi_pkg::TIMER_RST;
      end else if (ce_i && vel_en) begin
         if (expire) begin
            timer_reg <= load_reg; // see R19
         end else begin
            timer_reg <= timer_reg - 32'h00000001;
         end
      end
   end

   // A pulse in the expiry cycle starts the new tally, not lost
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         tally_reg <= evi_pkg::TALLY_RST; // see R6
         speed_reg <= evi_pkg::SPEED_RST;
      end else if (ce_i && vel_en) begin // see R2, R4
         if (expire) begin
            speed_reg <= tally_reg; // see R3, R20
            tally_reg <= {31'h00000000, inc}; // see R20
         end else begin
            tally_reg <= tally_reg + {31'h00000000, inc}; // see R1
         end
      end
   end

   // Set wins over a clear arriving in the same cycle
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         raw_reg <= evi_pkg::EVENT_RST;
      end else if (ce_i) begin
         raw_reg <= (raw_reg & ~ev_clr) | ev_set; // see R13, R15
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         irq_reg <= 1'b0;
      end else if (ce_i) begin
         irq_reg <= |(raw_reg & enable_reg); // see R7
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         control_reg <= evi_pkg::CONTROL_RST;
         load_reg <= evi_pkg::LOAD_RST;
         enable_reg <= evi_pkg::EVENT_RST;
      end else if (ce_i && do_write) begin
         if (wr_addr_reg == evi_pkg::OFS_CONTROL) begin
            control_reg <= (control_reg & ~(strb_mask & evi_pkg::CTL_WR_MASK))
               | (wr_data_reg & strb_mask & evi_pkg::CTL_WR_MASK);
         end
         if (wr_addr_reg == evi_pkg::OFS_PERIOD_LOAD) begin
            load_reg <= (load_reg & ~strb_mask) | (wr_data_reg & strb_mask);
         end
         if (wr_addr_reg == evi_pkg::OFS_IRQ_ENABLE && wr_strb_reg[0]) begin
            enable_reg <= wr_data_reg[3:0];
         end
      end
   end

   // Write channel: address and data taken in either order
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         aw_ready_reg <= 1'b0;
         aw_held_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end else if (ce_i) begin
         if (aw_ready_reg && s_axi_awvalid_i) begin
            aw_ready_reg <= 1'b0;
            aw_held_reg <= 1'b1;
            wr_addr_reg <= {s_axi_awaddr_i[7:2], 2'h0};
         end else if (do_write) begin
            aw_held_reg <= 1'b0;
         end else if (!aw_held_reg && !b_valid_reg) begin
            aw_ready_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         w_ready_reg <= 1'b0;
         w_held_reg <= 1'b0;
         wr_data_reg <= 32'h00000000;
         wr_strb_reg <= 4'h0;
      end else if (ce_i) begin
         if (w_ready_reg && s_axi_wvalid_i) begin
            w_ready_reg <= 1'b0;
            w_held_reg <= 1'b1;
            wr_data_reg <= s_axi_wdata_i;
            wr_strb_reg <= s_axi_wstrb_i;
         end else if (do_write) begin
            w_held_reg <= 1'b0;
         end else if (!w_held_reg && !b_valid_reg) begin
            w_ready_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         b_valid_reg <= 1'b0;
         b_resp_reg <= evi_pkg::RESP_OKAY;
      end else if (ce_i) begin
         if (do_write) begin
            b_valid_reg <= 1'b1;
            b_resp_reg <= wr_hit_ok ? evi_pkg::RESP_OKAY : evi_pkg::RESP_SLVERR;
         end else if (b_valid_reg && s_axi_bready_i) begin
            b_valid_reg <= 1'b0;
         end
      end
   end

   // Read channel; reads have no side effects
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ar_ready_reg <= 1'b0;
         r_valid_reg <= 1'b0;
         r_data_reg <= 32'h00000000;
         r_resp_reg <= evi_pkg::RESP_OKAY;
      end else if (ce_i) begin
         if (ar_ready_reg && s_axi_arvalid_i) begin
            ar_ready_reg <= 1'b0;
            r_valid_reg <= 1'b1;
            r_resp_reg <= evi_pkg::RESP_OKAY;
            // Reserved event bits read zero
            case ({s_axi_araddr_i[7:2], 2'h0})
               evi_pkg::OFS_CONTROL: r_data_reg <= control_reg;
               evi_pkg::OFS_PERIOD_LOAD: r_data_reg <= load_reg;
               evi_pkg::OFS_TIMER_VALUE: r_data_reg <= timer_reg;
               evi_pkg::OFS_PULSE_TALLY: r_data_reg <= tally_reg; // see R1, R5
               evi_pkg::OFS_MEAS_VELOCITY: r_data_reg <= speed_reg; // see R3
               evi_pkg::OFS_IRQ_ENABLE: r_data_reg <= {28'h0000000, enable_reg}; // see R16
               evi_pkg::OFS_RAW_STATUS: r_data_reg <= {28'h0000000, raw_reg}; // see R12
               evi_pkg::OFS_MASKED_CLEAR: r_data_reg <= {28'h0000000, raw_reg & enable_reg}; // see R14
               default: begin
                  r_data_reg <= 32'h00000000;
                  r_resp_reg <= evi_pkg::RESP_SLVERR;
               end
            endcase
         end else if (r_valid_reg && s_axi_rready_i) begin
            r_valid_reg <= 1'b0;
         end else if (!r_valid_reg && !ar_ready_reg) begin
            ar_ready_reg <= 1'b1;
         end
      end
   end

   assign s_axi_awready_o = aw_ready_reg;
   assign s_axi_wready_o = w_ready_reg;
   assign s_axi_bvalid_o = b_valid_reg;
   assign s_axi_bresp_o = b_resp_reg;
   assign s_axi_arready_o = ar_ready_reg;
   assign s_axi_rvalid_o = r_valid_reg;
   assign s_axi_rdata_o = r_data_reg;
   assign s_axi_rresp_o = r_resp_reg;
   assign irq_o = irq_reg;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);

   tally_hold_a: assert property (ce_i && !vel_en |=> $stable(tally_reg)) // see R2
      else $error("tally moved while velocity disabled");
   speed_hold_a: assert property (!vel_en |=> $stable(speed_reg)) // see R4
      else $error("speed moved while velocity disabled");
   speed_capture_a: assert property (ce_i && expire |=> speed_reg == $past(tally_reg)) // see R3
      else $error("speed did not capture tally at expiry");
   tally_restart_a: assert property (ce_i && expire |=> tally_reg <= 32'h00000001) // see R20
      else $error("tally not restarted at expiry");
   tally_count_a: assert property (ce_i && vel_en && !expire
      |=> tally_reg == $past(tally_reg) + {31'h00000000, $past(inc)}) // see R1
      else $error("tally did not follow predivided pulses");
   timer_reload_a: assert property (ce_i && expire |=> timer_reg == $past(load_reg)) // see R19
      else $error("timer did not reload");
   expiry_event_a: assert property (ce_i && expire |=> raw_reg[evi_pkg::EV_TIMER]) // see R10
      else $error("expiry not latched");
   irq_mask_a: assert property (ce_i |=> irq_reg == |($past(raw_reg) & $past(enable_reg))) // see R7
      else $error("interrupt does not match enabled events");
   set_latch_a: assert property (ce_i && |ev_set |=> (raw_reg & $past(ev_set)) == $past(ev_set)) // see R13
      else $error("event not latched");
   clear_one_a: assert property (ce_i && |(ev_clr & ~ev_set)
      |=> (raw_reg & $past(ev_clr & ~ev_set)) == 4'h0) // see R15
      else $error("write of one did not clear event");
   clear_keep_a: assert property (ce_i |=> ($past(raw_reg) & ~$past(ev_clr) & ~raw_reg) == 4'h0) // see R21
      else $error("event lost without a clearing write");
   write_resp_a: assert property (aw_held_reg && w_held_reg && !b_valid_reg && ce_i |=> b_valid_reg)
      else $error("write response missing");

   expiry_c: cover property (ce_i && expire && tally_reg != 32'h00000000);
   clear_c: cover property (ce_i && |ev_clr);
   irq_c: cover property (ce_i && !irq_reg ##1 irq_reg);
   read_c: cover property (r_valid_reg && s_axi_rready_i);
endmodule : evi_top
`default_nettype wire

// >>> tb/evi_enc_model.sv
// Purpose: Quadrature encoder model driving the phase and index pins
// Assumes: Pins change by non-blocking assignment just after a clock edge
// Notes: Each change is held at least three edges so the synchroniser sees it
`timescale 1ns/1ps
`default_nettype none
module evi_enc_model (
   input wire logic clk_i,
   output logic phase_a_o,
   output logic phase_b_o,
   output logic index_o
);
   logic [1:0] pos_reg = 2'h0;
   logic index_reg = 1'b0;
   // Gray sequence 00, 01, 11, 10 for forward rotation
   assign phase_a_o = pos_reg[1];
   assign phase_b_o = pos_reg[1] ^ pos_reg[0];
   assign index_o = index_reg;
   task automatic step(input logic fwd, input int hold);
      @(posedge clk_i);
      pos_reg <= fwd ? pos_reg + 2'h1 : pos_reg - 2'h1;
      repeat (hold) @(posedge clk_i);
   endtask : step
   // Both phases move at once, which a real encoder never does
   task automatic glitch();
      @(posedge clk_i);
      pos_reg <= pos_reg + 2'h2;
      repeat (4) @(posedge clk_i);
   endtask : glitch
   task automatic index_pulse();
      @(posedge clk_i);
      index_reg <= 1'b1;
      repeat (4) @(posedge clk_i);
      index_reg <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask : index_pulse
endmodule : evi_enc_model
`default_nettype wire

// >>> tb/evi_top_tb_top.sv
// Purpose: Register-level test of velocity capture and event latching
// Assumes: AXI4-Lite master tasks; encoder model on the pins
// Notes: Period load 999 keeps each velocity period at 1000 cycles
`timescale 1ns/1ps
`default_nettype none
module evi_top_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire logic awready, wready, bvalid, arready, rvalid, irq, pha, phb, idx;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   int fails = 0;
   int total_checks = 0;
   logic [31:0] rd_d;
   logic [1:0] rd_r;
   evi_top i_dut (.clk_i(clk), .reset_i(rst), .ce_i(ce), .phase_a_i(pha), .phase_b_i(phb), .index_i(idx),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .irq_o(irq));
   evi_enc_model u_enc (.clk_i(clk), .phase_a_o(pha), .phase_b_o(phb), .index_o(idx));
   initial begin
      forever #2 clk = ~clk;
   end
   task automatic report_and_stop();
      $display("checks=%0d fails=%0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk32
   task automatic chk1(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk1
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axi_rd
   // Data is compared under a mask so that only the bits under test are checked
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
      axi_rd(a, rd_d, rd_r);
      chk32(rd_d & m, e);
      chk32({30'h0, rd_r}, {30'h0, er});
   endtask : rd_chk
   task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      axi_wr(a, d, rd_r);
      chk32({30'h0, rd_r}, {30'h0, er});
   endtask : wr_chk
   task automatic wait_timer();
      int n;
      n = 0;
      do begin
         axi_rd(evi_pkg::OFS_RAW_STATUS, rd_d, rd_r);
         n++;
      end while (rd_d[1] !== 1'b1 && n < 400);
      chk1(rd_d[1], 1'b1);
   endtask : wait_timer
   initial begin
      #300000;
      fails++;
      report_and_stop();
   end
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      for (int i = 0; i < 5; i++) begin
         rd_chk(8'h18 + 8'(4 * i), (i < 2) ? 32'hFFFFFFFF : 32'hF, 32'h0, evi_pkg::RESP_OKAY);
      end
      rd_chk(8'h30, 32'h0, 32'h0, evi_pkg::RESP_SLVERR);
      wr_chk(evi_pkg::OFS_RAW_STATUS, 32'hF, evi_pkg::RESP_SLVERR);
      wr_chk(evi_pkg::OFS_PULSE_TALLY, 32'h5, evi_pkg::RESP_SLVERR);
      rd_chk(evi_pkg::OFS_RAW_STATUS, 32'hF, 32'h0, evi_pkg::RESP_OKAY);
      wr_chk(evi_pkg::OFS_IRQ_ENABLE, 32'hFFFFFFFF, evi_pkg::RESP_OKAY);
      rd_chk(evi_pkg::OFS_IRQ_ENABLE, 32'hF, 32'hF, evi_pkg::RESP_OKAY);
      wr_chk(evi_pkg::OFS_IRQ_ENABLE, 32'h0, evi_pkg::RESP_OKAY);
      wr_chk(evi_pkg::OFS_PERIOD_LOAD, 32'd999, evi_pkg::RESP_OKAY);
      for (int i = 0; i < 5; i++) u_enc.step(1'b1, 4);
      rd_chk(evi_pkg::OFS_PULSE_TALLY, 32'hFFFFFFFF, 32'h0, evi_pkg::RESP_OKAY);
      // Forward steps from reset are no direction change
      rd_chk(evi_pkg::OFS_RAW_STATUS, 32'h6, 32'h0, evi_pkg::RESP_OKAY);
      // One tally or more per period at every code, so each divider is told apart
      for (int code = 0; code < 8; code++) begin
         int nst;
         nst = (code < 3) ? 8 : (1 << code);
         wr_chk(evi_pkg::OFS_CONTROL, 32'h20 | 32'(code << 6), evi_pkg::RESP_OKAY);
         // Timer starts at zero: reload one edge after enable, then one decrement
         if (code == 0) rd_chk(evi_pkg::OFS_TIMER_VALUE, 32'hFFFFFFFF, 32'd998, evi_pkg::RESP_OKAY);
         wait_timer();
         wr_chk(evi_pkg::OFS_MASKED_CLEAR, 32'h2, evi_pkg::RESP_OKAY);
         for (int i = 0; i < nst; i++) u_enc.step(1'b1, (code < 4) ? code + 3 : 3);
         rd_chk(evi_pkg::OFS_PULSE_TALLY, 32'hFFFFFFFF, 32'(nst >> code), evi_pkg::RESP_OKAY);
         wait_timer();
         rd_chk(evi_pkg::OFS_MEAS_VELOCITY, 32'hFFFFFFFF, 32'(nst >> code), evi_pkg::RESP_OKAY);
      end
      wr_chk(evi_pkg::OFS_CONTROL, 32'h0, evi_pkg::RESP_OKAY);
      wr_chk(evi_pkg::OFS_MASKED_CLEAR, 32'hF, evi_pkg::RESP_OKAY);
      for (int i = 0; i < 3; i++) u_enc.step(1'b1, 4);
      repeat (1100) @(posedge clk);
      rd_chk(evi_pkg::OFS_MEAS_VELOCITY, 32'hFFFFFFFF, 32'h1, evi_pkg::RESP_OKAY);
      rd_chk(evi_pkg::OFS_RAW_STATUS, 32'h2, 32'h0, evi_pkg::RESP_OKAY);
      wr_chk(evi_pkg::OFS_IRQ_ENABLE, 32'h1, evi_pkg::RESP_OKAY);
      u_enc.glitch();
      u_enc.index_pulse();
      rd_chk(evi_pkg::OFS_RAW_STATUS, 32'h9, 32'h9, evi_pkg::RESP_OKAY);
      rd_chk(evi_pkg::OFS_MASKED_CLEAR, 32'hF, 32'h1, evi_pkg::RESP_OKAY);
      chk1(irq, 1'b1);
      wr_chk(evi_pkg::OFS_MASKED_CLEAR, 32'h0, evi_pkg::RESP_OKAY);
      rd_chk(evi_pkg::OFS_RAW_STATUS, 32'h9, 32'h9, evi_pkg::RESP_OKAY);
      wr_chk(evi_pkg::OFS_MASKED_CLEAR, 32'h1, evi_pkg::RESP_OKAY);
      rd_chk(evi_pkg::OFS_RAW_STATUS, 32'h9, 32'h8, evi_pkg::RESP_OKAY);
      chk1(irq, 1'b0);
      wr_chk(evi_pkg::OFS_MASKED_CLEAR, 32'hF, evi_pkg::RESP_OKAY);
      u_enc.step(1'b1, 4);
      u_enc.step(1'b1, 4);
      wr_chk(evi_pkg::OFS_MASKED_CLEAR, 32'hF, evi_pkg::RESP_OKAY);
      u_enc.step(1'b0, 4);
      wr_chk(evi_pkg::OFS_IRQ_ENABLE, 32'h4, evi_pkg::RESP_OKAY);
      rd_chk(evi_pkg::OFS_MASKED_CLEAR, 32'hF, 32'h4, evi_pkg::RESP_OKAY);
      chk1(irq, 1'b1);
      wr_chk(evi_pkg::OFS_MASKED_CLEAR, 32'hF, evi_pkg::RESP_OKAY);
      rd_chk(evi_pkg::OFS_RAW_STATUS, 32'hF, 32'h0, evi_pkg::RESP_OKAY);
      chk1(irq, 1'b0);
      // An index pulse while the clock enable is low must leave no trace
      ce <= 1'b0;
      u_enc.index_pulse();
      ce <= 1'b1;
      rd_chk(evi_pkg::OFS_RAW_STATUS, 32'hF, 32'h0, evi_pkg::RESP_OKAY);
      report_and_stop();
   end
endmodule : evi_top_tb_top
`default_nettype wire
